//--- shared/ple_pkg.sv
// constants shared by the logic-equation engine and its counter memory
// assumes one 100 MHz clock; configuration ports are held steady by the relay firmware
package ple_pkg;
  localparam int       PLE_NUM_EQ     = 8;
  localparam int       PLE_NUM_SIG    = 16;
  localparam int       PLE_TIMER_W    = 16;
  localparam int       PLE_NUM_IN     = 4;
  localparam int       PLE_OP_W       = 2;
  localparam bit [1:0] PLE_OP_AND     = 2'h0;
  localparam bit [1:0] PLE_OP_OR      = 2'h1;
  localparam bit [1:0] PLE_OP_NAND    = 2'h2;
  localparam bit [1:0] PLE_OP_NOR     = 2'h3;
  localparam int       PLE_MIN_EQ     = 2;
endpackage : ple_pkg

//--- verilog/ple_cnt_mem.sv
// per-equation delay counter store with a registered read port
// assumes the reader never reads the word written in the same cycle
`timescale 1ns/10ps
`default_nettype none
module ple_cnt_mem
  import ple_pkg::*;
#(
  parameter int DEPTH = PLE_NUM_EQ,
  parameter int WIDTH = PLE_TIMER_W,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [AW-1:0]    rd_addr,
  output var  logic [WIDTH-1:0] rd_data,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  if (DEPTH < 2 || WIDTH < 1 || AW < $clog2(DEPTH)) begin : g_bad_size
    $error("ple_cnt_mem depth or width out of range");
  end

  // small depth, so clearing every word at reset is cheap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule // ple_cnt_mem
`default_nettype wire

//--- verilog/ple_engine.sv
// sequential logic-equation engine: one equation evaluated per clock
// assumes external signals are asynchronous; configuration is quasi-static
`timescale 1ns/10ps
`default_nettype none
module ple_engine
  import ple_pkg::*;
#(
  parameter int NUM_EQ  = PLE_NUM_EQ,
  parameter int NUM_SIG = PLE_NUM_SIG,
  parameter int TW      = PLE_TIMER_W,
  parameter int POOL    = NUM_SIG + 3 * NUM_EQ,
  parameter int SELW    = $clog2(POOL),
  parameter int IW      = $clog2(NUM_EQ)
) (
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  input  wire logic [NUM_SIG-1:0]              sig_in,
  input  wire logic [NUM_EQ*PLE_NUM_IN*SELW-1:0] in_sel,
  input  wire logic [NUM_EQ*PLE_NUM_IN-1:0]    in_inv,
  input  wire logic [NUM_EQ*PLE_NUM_IN-1:0]    in_used,
  input  wire logic [NUM_EQ*PLE_OP_W-1:0]      gate_op,
  input  wire logic [NUM_EQ*TW-1:0]            on_delay_time,
  input  wire logic [NUM_EQ*TW-1:0]            off_delay_time,
  input  wire logic [NUM_EQ*SELW-1:0]          rst_sel,
  input  wire logic [NUM_EQ-1:0]               rst_inv,
  output var  logic [NUM_EQ-1:0]               logic_equation_out,
  output var  logic [NUM_EQ-1:0]               latched_out,
  output var  logic [NUM_EQ-1:0]               latched_n_out,
  output var  logic                            pass_done
);
  if (NUM_EQ < PLE_MIN_EQ) begin : g_bad_eq
    $error("ple_engine needs at least two equations");
  end
  if (TW < 1) begin : g_bad_tw
    $error("ple_engine timer width must be positive");
  end
  if (NUM_SIG < 1 || POOL != NUM_SIG + 3 * NUM_EQ || SELW < $clog2(POOL)
      || IW < $clog2(NUM_EQ)) begin : g_bad_width
    $error("ple_engine selector or index width too small");
  end

  // ==========================================================
  // input synchronisation and per-pass snapshot
  logic [NUM_SIG-1:0] sig_meta_reg;
  logic [NUM_SIG-1:0] sig_sync_reg;
  logic [NUM_SIG-1:0] sig_snap_reg;
  logic [IW-1:0]      idx_reg;
  logic [IW-1:0]      idx_next;
  logic               last_eq;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sig_meta_reg <= '0;
      sig_sync_reg <= '0;
    end else begin
      sig_meta_reg <= sig_in;
      sig_sync_reg <= sig_meta_reg;
    end
  end

  // one snapshot per pass keeps all equations of a pass on the same inputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sig_snap_reg <= '0;
    end else if (last_eq) begin
      sig_snap_reg <= sig_sync_reg;
    end
  end

  // ==========================================================
  // evaluation sequencer
  assign last_eq  = (idx_reg == IW'(NUM_EQ - 1));
  assign idx_next = last_eq ? '0 : idx_reg + 1'b1;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_reg <= '0;
    end else begin
      idx_reg <= idx_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pass_done <= 1'b0;
    end else begin
      pass_done <= last_eq;
    end
  end

  // ==========================================================
  // selection from the assignment list
  logic [POOL-1:0] pool;
  // outputs live in the same pool and are updated in place, so lower
  // equations show this pass's value and higher ones the previous pass's
  assign pool = {latched_n_out, latched_out, logic_equation_out, sig_snap_reg};

  function automatic logic pick(input logic [SELW-1:0] sel, input logic [POOL-1:0] p);
    logic v;
    v = 1'b0;
    if (int'(sel) < POOL) begin
      v = p[sel];
    end
    return v;
  endfunction

  // ==========================================================
  // gate, timer and latch of the current equation
  logic [TW-1:0] cnt_rd;
  logic [TW-1:0] cnt_wr;
  logic [TW:0]   cnt_inc;
  logic [TW-1:0] dly;
  logic [1:0]    op;
  logic          gate_val;
  logic          any_in;
  logic          all_in;
  logic          dir_cur;
  logic          dir_new;
  logic          rst_cond;
  logic          lat_new;
  logic          term;

  always_comb begin
    term   = 1'b0;
    any_in = 1'b0;
    all_in = 1'b1;
    op     = gate_op[idx_reg*PLE_OP_W +: PLE_OP_W];
    for (int k = 0; k < PLE_NUM_IN; k++) begin
      term = pick(in_sel[(int'(idx_reg)*PLE_NUM_IN+k)*SELW +: SELW], pool)
             ^ in_inv[int'(idx_reg)*PLE_NUM_IN+k];
      // unused inputs drop out: ones for AND, zeros for OR
      if (in_used[int'(idx_reg)*PLE_NUM_IN+k]) begin
        any_in = any_in | term;
        all_in = all_in & term;
      end
    end
    case (op)
      PLE_OP_AND:  gate_val = all_in;
      PLE_OP_OR:   gate_val = any_in;
      PLE_OP_NAND: gate_val = ~all_in;
      PLE_OP_NOR:  gate_val = ~any_in;
      default:     gate_val = all_in;
    endcase
  end

  // delays are in passes; a delay of 0 or 1 acts on the first pass
  always_comb begin
    dir_cur = logic_equation_out[idx_reg];
    dly     = gate_val ? on_delay_time[idx_reg*TW +: TW]
                       : off_delay_time[idx_reg*TW +: TW];
    cnt_inc = {1'b0, cnt_rd} + 1'b1;
    dir_new = dir_cur;
    cnt_wr  = '0;
    if (gate_val != dir_cur) begin
      if (cnt_inc >= {1'b0, dly}) begin
        dir_new = gate_val;
      end else begin
        cnt_wr = cnt_inc[TW-1:0];
      end
    end
  end

  always_comb begin
    rst_cond = pick(rst_sel[idx_reg*SELW +: SELW], pool) ^ rst_inv[idx_reg];
    lat_new  = rst_cond ? 1'b0 : (latched_out[idx_reg] | dir_new);
  end

  ple_cnt_mem #(
    .DEPTH (NUM_EQ),
    .WIDTH (TW),
    .AW    (IW)
  ) u_cnt_mem (
    .clk     (clk),
    .rst_b   (rst_b),
    .rd_addr (idx_next),
    .rd_data (cnt_rd),
    .wr_en   (1'b1),
    .wr_addr (idx_reg),
    .wr_data (cnt_wr)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      logic_equation_out <= '0;
    end else begin
      logic_equation_out[idx_reg] <= dir_new;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latched_out   <= '0;
      latched_n_out <= '1;
    end else begin
      latched_out[idx_reg]   <= lat_new;
      latched_n_out[idx_reg] <= ~lat_new;
    end
  end

  // ==========================================================
  // assertions
  a_idx_wrap: assert property (@(posedge clk) disable iff (!rst_b)
    last_eq |=> idx_reg == '0) else $error("pass did not restart at equation 0");
  a_idx_step: assert property (@(posedge clk) disable iff (!rst_b)
    !last_eq |=> idx_reg == $past(idx_reg) + 1'b1) else $error("order not ascending");
  a_latch_compl: assert property (@(posedge clk) disable iff (!rst_b)
    latched_n_out == ~latched_out) else $error("latched complement wrong");
  a_reset_wins: assert property (@(posedge clk) disable iff (!rst_b)
    (rst_cond && dir_new) |=> !latched_out[$past(idx_reg)]) else $error("set beat reset");
  a_latch_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (!rst_cond && latched_out[idx_reg]) |=> latched_out[$past(idx_reg)])
    else $error("latch dropped without reset");
  a_zero_delay: assert property (@(posedge clk) disable iff (!rst_b)
    (on_delay_time[idx_reg*TW +: TW] == '0 && off_delay_time[idx_reg*TW +: TW] == '0)
    |=> logic_equation_out[$past(idx_reg)] == $past(gate_val))
    else $error("undelayed output does not follow gate");
  a_rise_waits: assert property (@(posedge clk) disable iff (!rst_b)
    (gate_val && !dir_cur && cnt_inc < {1'b0, dly})
    |=> !logic_equation_out[$past(idx_reg)]) else $error("on delay cut short");
  a_fall_waits: assert property (@(posedge clk) disable iff (!rst_b)
    (!gate_val && dir_cur && cnt_inc < {1'b0, dly})
    |=> logic_equation_out[$past(idx_reg)]) else $error("off delay cut short");
  a_one_update: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 ((logic_equation_out ^ $past(logic_equation_out))
         & ~(NUM_EQ'(1) << $past(idx_reg))) == '0)
    else $error("equation changed outside its slot");
  a_pass_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    pass_done |-> idx_reg == '0 ##1 !pass_done) else $error("pass strobe misplaced");

  c_latch_set:   cover property (@(posedge clk) disable iff (!rst_b) $rose(latched_out[0]));
  c_latch_reset: cover property (@(posedge clk) disable iff (!rst_b) rst_cond && dir_new);
  c_delayed:     cover property (@(posedge clk) disable iff (!rst_b)
    gate_val != dir_cur && cnt_inc < {1'b0, dly});
  c_pass:        cover property (@(posedge clk) disable iff (!rst_b) pass_done [*1] ##8 pass_done);
endmodule // ple_engine
`default_nettype wire

//--- bench/test_programmable_logic_equations.sv
// bench for the logic-equation engine: gates, timers, latch and cascades
// assumes default engine parameters; inputs change at the falling edge
`timescale 1ns/10ps
`default_nettype none
module test_programmable_logic_equations
  import ple_pkg::*;
;
  localparam int NE = PLE_NUM_EQ;
  localparam int NS = PLE_NUM_SIG;
  localparam int SW = $clog2(NS + 3 * NE);
  logic              clk, rst_b, done;
  logic [NS-1:0]     sig;
  logic [NE*4*SW-1:0] isel;
  logic [NE*4-1:0]   iinv, iuse;
  logic [NE*2-1:0]   op;
  logic [NE*16-1:0]  ond, offd;
  logic [NE*SW-1:0]  rsel;
  logic [NE-1:0]     rinv, q, l, ln;
  logic [2:0]        a;
  logic              e;
  int                n_errors, n_tests, c, n;

  ple_engine DUT (.clk(clk), .rst_b(rst_b), .sig_in(sig), .in_sel(isel), .in_inv(iinv),
    .in_used(iuse), .gate_op(op), .on_delay_time(ond), .off_delay_time(offd),
    .rst_sel(rsel), .rst_inv(rinv), .logic_equation_out(q), .latched_out(l),
    .latched_n_out(ln), .pass_done(done));

  // ==========================================
  // helpers
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task pin(input int eq, input int k, input int s, input int inv);
    isel[(eq*4+k)*SW +: SW] = s[SW-1:0];
    iinv[eq*4+k] = inv[0];
    iuse[eq*4+k] = 1'b1;
  endtask
  // bounded wait so a dead pass counter cannot hang the run
  task passes(input int p);
    repeat (p) begin
      c = 0;
      while (done !== 1'b1 && c < 40) begin
        @(negedge clk);
        c++;
      end
      if (c >= 40) begin
        n_errors++;
        $display("unexpected at %0t: pass strobe missing", $time);
      end
      @(negedge clk);
    end
  endtask
  task rise(input int b);
    n = 0;
    while (q[b] !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
  endtask
  task give_verdict;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100us;
    n_errors++;
    $display("unexpected at %0t: run timed out", $time);
    give_verdict();
  end

  // ==========================================
  // tests
  initial begin
    n_errors = 0;
    n_tests = 0;
    rst_b = 1'b0;
    sig = '0;
    isel = '0;
    iinv = '0;
    iuse = '0;
    op = {NE{PLE_OP_OR}}; // empty or gates idle low, so later timers start from 0
    ond = '0;
    offd = '0;
    rsel = '1; // codes past the pool read 0: no latch reset
    rinv = '0;
    repeat (10) @(negedge clk);
    chk(q, 8'h00);
    chk(ln, 8'hff);
    rst_b = 1'b1;
    // input 3 left unused to show it is neutral
    isel[3*SW +: SW] = 6'h03; // signal 3 would upset the gate if it were counted
    pin(0, 0, 0, 0);
    pin(0, 1, 1, 1);
    pin(0, 2, 2, 0);
    for (int o = 0; o < 4; o++) begin
      for (int p = 0; p < 8; p++) begin
        op[1:0] = o[1:0];
        sig[3:0] = {o[0], p[2:0]};
        passes(3);
        a = {p[2], ~p[1], p[0]};
        e = (o == 0) ? &a : (o == 1) ? |a : (o == 2) ? ~&a : ~|a;
        chk({7'h00, q[0]}, {7'h00, e});
      end
    end
    chk({7'h00, l[0]}, 8'h01);
    chk({7'h00, ln[0]}, 8'h00);
    // timer: on 5 passes, off 3 passes; reset from signal 5
    pin(1, 0, 4, 0);
    op[3:2] = PLE_OP_OR;
    ond[31:16] = 16'h0005;
    offd[31:16] = 16'h0003;
    rsel[2*SW-1:SW] = 6'h05;
    sig[4] = 1'b1;
    passes(5);
    chk({7'h00, q[1]}, 8'h00);
    passes(1);
    chk({7'h00, q[1]}, 8'h01);
    sig[4] = 1'b0;
    passes(3);
    chk({7'h00, q[1]}, 8'h01);
    passes(1);
    chk({7'h00, q[1]}, 8'h00);
    chk({7'h00, l[1]}, 8'h01);
    chk({7'h00, ln[1]}, 8'h00);
    sig[5:4] = 2'b11;
    passes(8);
    chk({7'h00, q[1]}, 8'h01);
    chk({7'h00, l[1]}, 8'h00);
    rinv[1] = 1'b1;
    passes(2);
    chk({7'h00, l[1]}, 8'h01);
    sig[5] = 1'b0;
    passes(2);
    chk({7'h00, ln[1]}, 8'h01);
    rinv[1] = 1'b0;
    sig[4] = 1'b0;
    ond = '0;
    offd = '0;
    passes(3);
    // cascades: eq1 feeds eq2 upward, eq3 feeds eq0 downward
    pin(2, 0, NS + 1, 0);
    op[5:4] = PLE_OP_OR;
    pin(3, 0, 6, 0);
    op[7:6] = PLE_OP_OR;
    iuse[3:0] = 4'h0;
    pin(0, 0, NS + 3, 0);
    op[1:0] = PLE_OP_OR;
    // eq4 reads the latch complement of eq1, eq5 the latch itself
    pin(4, 0, NS + 2 * NE + 1, 0);
    pin(5, 0, NS + NE + 1, 0);
    passes(2);
    sig[4] = 1'b1;
    rise(1);
    rise(2);
    chk(n[7:0], 8'h01);
    sig[6] = 1'b1;
    rise(3);
    rise(0);
    chk(n[7:0], 8'(NE - 3));
    passes(1);
    n = 1;
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(n[7:0], 8'(NE));
    chk({6'h00, q[5:4]}, 8'h02);
    give_verdict();
  end
endmodule // test_programmable_logic_equations
`default_nettype wire
